// ==== design/cb_stop_pkg.sv ====
// Constants shared by the balancing stop controller and its helpers.
// Assumes one 50 MHz clock and a 32-bit Avalon-MM register bus.
package cb_stop_pkg;
  localparam int CELLS = 14;
  localparam int EXP_W = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int PER_W = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAL = 8'h04;
  localparam logic [7:0] OFS_GRP_EXP = 8'h08;
  localparam logic [7:0] OFS_SWEN = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TIMER = 8'h18;
  localparam logic [7:0] OFS_UV = 8'h1c;
  localparam logic [1:0] CELL_EXP_PAGE = 2'h1;

  // Control, data and status register fields
  localparam int MODE_LSB = 0;
  localparam int MEAS_LSB = 4;
  localparam int TEMP_BIT = 8;
  localparam int APPLY_BIT = 9;
  localparam int PAUSE_BIT = 10;
  localparam int HOLD_LSB = 12;
  localparam int COPY_BIT = 0;
  localparam int AUTO_BIT = 2;
  localparam int GROUP_BIT = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_CAL = 3;
  localparam int STAT_TEMP = 4;

  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_DISCH = 3'h1;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MEAS_UV = 2'h3;
  localparam logic [1:0] ST_IDLE = 2'h0;
  localparam logic [1:0] ST_RUN = 2'h1;
  localparam logic [1:0] ST_NORMAL = 2'h2;
  localparam logic [1:0] ST_ABNORMAL = 2'h3;
  localparam logic [1:0] HOLD_TIMER = 2'h1;
  localparam logic [1:0] HOLD_EXT = 2'h2;
  localparam logic [1:0] HOLD_WRITE = 2'h3;
  localparam logic [EXP_W-1:0] EXP_INFINITE = 10'h3ff;
  localparam logic [DATA_W-1:0] REG_RST = 32'h0;

  // Timer tick and post-expiry hold, in their own units
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_TIME_MS = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int HOLD_EXT_TIME_S = 300;
  localparam int HOLD_EXT_TICKS = HOLD_EXT_TIME_S * 1000 / TICK_TIME_MS;

  // Measurement cycles per calibration for each interval selection
  function automatic logic [PER_W-1:0] cal_period(input logic [2:0] sel);
    case (sel)
      3'h1: cal_period = 6'h02;
      3'h2: cal_period = 6'h04;
      3'h3: cal_period = 6'h08;
      3'h4: cal_period = 6'h0c;
      3'h5: cal_period = 6'h10;
      3'h6: cal_period = 6'h18;
      3'h7: cal_period = 6'h20;
      default: cal_period = 6'h00;
    endcase
  endfunction
endpackage

// ==== design/cal_interval_sched.sv ====
// Decides whether the next balancing operation is a calibration.
// Assumes op_done_i pulses once per finished operation, same clock.
`timescale 1ns/1ns
module cal_interval_sched (
  input wire logic ref_clk_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic restart_i, // New balancing run
  input wire logic enable_i, // Embedded measurements requested
  input wire logic [2:0] sel_i, // Calibration interval selection
  input wire logic op_done_i, // Operation finished
  input wire logic op_was_cal_i, // Finished operation was a calibration
  output logic cal_next_o // Next operation is a calibration
);
  logic first_reg;
  logic [cb_stop_pkg::PER_W-1:0] cnt_reg;
  logic [cb_stop_pkg::PER_W-1:0] period;

  assign period = cb_stop_pkg::cal_period(sel_i);

  // Zero selection or no measurements means never calibrate
  assign cal_next_o = enable_i && (period != '0) &&
    (first_reg || (cnt_reg >= period - 6'h01));

  // Count measurements since the last calibration
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (restart_i) begin
      first_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (op_done_i) begin
      if (op_was_cal_i) begin
        first_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (cnt_reg != '1) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end
endmodule

// ==== design/cell_uv_tracker.sv ====
// Per-cell sticky flags for cells that reached the undervoltage limit.
// Assumes check_i pulses with a valid per-cell comparison result.
`timescale 1ns/1ns
module cell_uv_tracker #(
  parameter int CELLS = cb_stop_pkg::CELLS
) (
  input wire logic ref_clk_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic clear_i, // Mode write clears all flags
  input wire logic check_i, // Comparison result valid
  input wire logic [CELLS-1:0] below_i, // Cell under limit
  input wire logic [CELLS-1:0] mask_i, // Enabled cells
  output logic [CELLS-1:0] reached_o // Cell reached limit
);
  // One flag per cell; a set in the clearing cycle still lands
  for (genvar n = 0; n < CELLS; n++) begin : g_cell
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        reached_o[n] <= 1'b0;
      end else if (check_i && below_i[n] && mask_i[n]) begin
        reached_o[n] <= 1'b1;
      end else if (clear_i) begin
        reached_o[n] <= 1'b0;
      end
    end
  end
endmodule

// ==== design/cell_balance_cal_stop_ctrl.sv ====
// Balancing calibration scheduling, fault reaction and stop control.
// Assumes the ADC engine, cell comparators and die-temperature alarm
// run on ref_clk_i; registers are reached over Avalon-MM.
// Operation
// - Interval ignored unless measurements requested
// - Zero interval means no calibrations
// - First operation becomes a calibration
// - Then one calibration every N cycles
// - Check range alert after each operation
// - Range alert sets fault, halts balancing
// - After fault skip all later cycles
// - Timer and hold continue after fault
// - Copy strobe moves filter results always
// - Copy deferred until running operation ends
// - Copy strobe self-clears, reads zero
// - Mode zero aborts, other mode restarts
// - Per-cell stop at undervoltage limit
// - Thermal fault halts discharge and automated runs when exit enabled
// - Calibration fault halts discharge and automated runs with measurements and apply on
// - Manual mode pauses switches during operations
// - Timer stops at group or largest expiry
// - Timer runs full time after stops
// - Expiry gives normal code and done
// - Faults abnormal, expiry or threshold normal
// - Stops keep mode; first cause reported
// - Mode zero clears undervoltage flags
// - Both measurement bits add threshold checks in automated modes
`timescale 1ns/1ns
module cell_balance_cal_stop_ctrl #(
  parameter int TICK_CYCLES = cb_stop_pkg::TICK_CYCLES,
  parameter int HOLD_EXT_TICKS = cb_stop_pkg::HOLD_EXT_TICKS
) (
  input wire logic ref_clk_i, // 50 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  output logic op_start_o, // Start ADC or calibration
  output logic op_is_cal_o, // Started operation is a calibration
  input wire logic op_done_i, // Operation finished pulse
  input wire logic cal_range_alert_i, // Calibration out of range
  input wire logic [13:0] cell_below_uv_i, // Per-cell under limit
  input wire logic thermal_fault_i, // Die overtemperature
  output logic [13:0] switch_on_o, // Balancing switch drive
  output logic iir_copy_o, // Copy filter results to cell data
  output logic shutdown_hold_o // Keep shutdown pin pulled up
);
  localparam int CELLS = cb_stop_pkg::CELLS;
  localparam int EXP_W = cb_stop_pkg::EXP_W;

  // Refuse settings the counters cannot serve
  if (TICK_CYCLES < 1 || HOLD_EXT_TICKS < 1 || HOLD_EXT_TICKS > 65535 ||
      CELLS != 14) begin : g_bad_param
    $error("cell_balance_cal_stop_ctrl: unsupported parameter");
  end

  typedef enum {OP_IDLE, OP_BUSY} op_state_e;

  // Merge write data into a register through the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction

  logic ack_reg;
  logic req;
  logic do_wr;
  logic ctrl_wr;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_new;
  logic [2:0] cal_sel_reg;
  logic [EXP_W-1:0] grp_exp_reg;
  logic [CELLS-1:0] swen_reg;
  logic [EXP_W-1:0] cell_exp_reg [CELLS];
  logic [1:0] state_reg;
  logic done_reg;
  logic cal_flt_reg;
  logic temp_flt_reg;
  logic [EXP_W-1:0] elapsed_reg;
  logic timing_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] ext_cnt_reg;
  logic copy_pend_reg;
  op_state_e op_state_reg;
  logic [CELLS-1:0] uv_reached;
  logic cal_next;
  logic [2:0] mode;
  logic [1:0] meas_en;
  logic [1:0] hold_sel;
  logic auto_md;
  logic manual_md;
  logic am_md;
  logic meas_req;
  logic running;
  logic [EXP_W-1:0] max_cell_exp;
  logic [EXP_W-1:0] limit;
  logic expire;
  logic op_fin;
  logic uv_check;
  logic cal_fault;
  logic temp_fault;
  logic all_reached;
  logic [15:0] ext_len;

  assign mode = ctrl_reg[cb_stop_pkg::MODE_LSB +: 3];
  assign meas_en = ctrl_reg[cb_stop_pkg::MEAS_LSB +: 2];
  assign hold_sel = ctrl_reg[cb_stop_pkg::HOLD_LSB +: 2];
  assign auto_md = mode[cb_stop_pkg::AUTO_BIT];
  assign manual_md = (mode[2:1] == cb_stop_pkg::MODE_MANUAL);
  assign am_md = auto_md || (mode == cb_stop_pkg::MODE_DISCH);
  // Embedded measurements only when the upper enable bit is set
  assign meas_req = meas_en[1];
  assign running = (state_reg == cb_stop_pkg::ST_RUN);

  // Bus handshake: one wait cycle, then the access takes effect
  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_reg;
  assign do_wr = avs_write_i && ack_reg;
  assign ctrl_wr = do_wr && (avs_address_i == cb_stop_pkg::OFS_CTRL);
  assign ctrl_new = merge(ctrl_reg, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // Read data captured while the bus waits, stands at the release edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= cb_stop_pkg::REG_RST;
    end else if (avs_read_i && !ack_reg) begin
      avs_readdata_o <= '0;
      case (avs_address_i)
        cb_stop_pkg::OFS_CTRL: avs_readdata_o <= ctrl_reg;
        cb_stop_pkg::OFS_CAL: avs_readdata_o[2:0] <= cal_sel_reg;
        cb_stop_pkg::OFS_GRP_EXP:
          avs_readdata_o[EXP_W-1:0] <= grp_exp_reg;
        cb_stop_pkg::OFS_SWEN: avs_readdata_o[CELLS-1:0] <= swen_reg;
        cb_stop_pkg::OFS_DATA: avs_readdata_o <= '0;
        cb_stop_pkg::OFS_STATUS: begin
          avs_readdata_o[1:0] <= state_reg;
          avs_readdata_o[cb_stop_pkg::STAT_DONE] <= done_reg;
          avs_readdata_o[cb_stop_pkg::STAT_CAL] <= cal_flt_reg;
          avs_readdata_o[cb_stop_pkg::STAT_TEMP] <= temp_flt_reg;
        end
        cb_stop_pkg::OFS_TIMER:
          avs_readdata_o[EXP_W-1:0] <= elapsed_reg;
        cb_stop_pkg::OFS_UV: avs_readdata_o[CELLS-1:0] <= uv_reached;
        default: begin
          if (avs_address_i[7:6] == cb_stop_pkg::CELL_EXP_PAGE &&
              avs_address_i[5:2] < 4'(CELLS)) begin
            avs_readdata_o[EXP_W-1:0] <= cell_exp_reg[avs_address_i[5:2]];
          end
        end
      endcase
    end
  end

  // Software-written configuration; unmapped writes are dropped
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= cb_stop_pkg::REG_RST;
      cal_sel_reg <= '0;
      grp_exp_reg <= '0;
      swen_reg <= '0;
      for (int n = 0; n < CELLS; n++) begin
        cell_exp_reg[n] <= '0;
      end
    end else if (do_wr) begin
      case (avs_address_i)
        cb_stop_pkg::OFS_CTRL: ctrl_reg <= ctrl_new;
        cb_stop_pkg::OFS_CAL: cal_sel_reg <= avs_byteenable_i[0] ?
          avs_writedata_i[2:0] : cal_sel_reg;
        cb_stop_pkg::OFS_GRP_EXP: grp_exp_reg <= EXP_W'(merge(
          32'(grp_exp_reg), avs_writedata_i, avs_byteenable_i));
        cb_stop_pkg::OFS_SWEN: swen_reg <= CELLS'(merge(
          32'(swen_reg), avs_writedata_i, avs_byteenable_i));
        default: begin
          if (avs_address_i[7:6] == cb_stop_pkg::CELL_EXP_PAGE &&
              avs_address_i[5:2] < 4'(CELLS)) begin
            cell_exp_reg[avs_address_i[5:2]] <= EXP_W'(merge(
              32'(cell_exp_reg[avs_address_i[5:2]]), avs_writedata_i,
              avs_byteenable_i));
          end
        end
      endcase
    end
  end

  // Governing expiry: group value, or largest per-cell value
  always_comb begin
    max_cell_exp = '0;
    for (int n = 0; n < CELLS; n++) begin
      if (cell_exp_reg[n] > max_cell_exp) begin
        max_cell_exp = cell_exp_reg[n];
      end
    end
  end
  assign limit = (auto_md && !mode[cb_stop_pkg::GROUP_BIT]) ?
    max_cell_exp : grp_exp_reg;

  // Timer tick divider; a long count, shortened in simulation
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= '0;
    end else if (ctrl_wr || tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1)) && !ctrl_wr;

  // Elapsed timer ignores switch masks and earlier stops
  assign expire = timing_reg && (elapsed_reg == limit) &&
    (limit != cb_stop_pkg::EXP_INFINITE);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      elapsed_reg <= '0;
      timing_reg <= 1'b0;
    end else if (ctrl_wr) begin
      elapsed_reg <= '0;
      timing_reg <= (ctrl_new[2:0] != cb_stop_pkg::MODE_OFF);
    end else if (expire) begin
      timing_reg <= 1'b0;
    end else if (timing_reg && tick && elapsed_reg != limit) begin
      elapsed_reg <= elapsed_reg + 10'h001;
    end
  end

  // Stop conditions seen this cycle
  assign op_fin = op_done_i && (op_state_reg == OP_BUSY);
  assign uv_check = op_fin && running && !op_is_cal_o && auto_md &&
    (meas_en == cb_stop_pkg::MEAS_UV);
  assign cal_fault = op_fin && running && am_md && meas_req &&
    ctrl_reg[cb_stop_pkg::APPLY_BIT] && cal_range_alert_i;
  assign temp_fault = running && am_md && thermal_fault_i &&
    ctrl_reg[cb_stop_pkg::TEMP_BIT];
  assign all_reached = auto_md && (meas_en == cb_stop_pkg::MEAS_UV) &&
    (swen_reg != '0) && ((uv_reached & swen_reg) == swen_reg);

  // Activity state: first cause to arrive is the one reported
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= cb_stop_pkg::ST_IDLE;
      done_reg <= 1'b0;
      cal_flt_reg <= 1'b0;
      temp_flt_reg <= 1'b0;
    end else if (ctrl_wr) begin
      state_reg <= (ctrl_new[2:0] == cb_stop_pkg::MODE_OFF) ?
        cb_stop_pkg::ST_IDLE : cb_stop_pkg::ST_RUN;
      // An event in the write cycle still lands
      done_reg <= expire;
      cal_flt_reg <= cal_fault;
      temp_flt_reg <= temp_fault;
    end else begin
      if (cal_fault) begin
        cal_flt_reg <= 1'b1;
      end
      if (temp_fault) begin
        temp_flt_reg <= 1'b1;
      end
      if (expire) begin
        done_reg <= 1'b1;
      end
      if (running) begin
        if (cal_fault || temp_fault) begin
          state_reg <= cb_stop_pkg::ST_ABNORMAL;
        end else if (expire || all_reached) begin
          state_reg <= cb_stop_pkg::ST_NORMAL;
        end
      end
    end
  end

  // Operation sequencer: one ADC or calibration per timer tick
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_state_reg <= OP_IDLE;
      op_start_o <= 1'b0;
      op_is_cal_o <= 1'b0;
    end else begin
      op_start_o <= 1'b0;
      case (op_state_reg)
        OP_IDLE: begin
          // Halted or finished runs skip every later cycle
          if (!ctrl_wr && running && timing_reg && !expire &&
              (am_md || manual_md) && meas_req && tick) begin
            op_state_reg <= OP_BUSY;
            op_start_o <= 1'b1;
            op_is_cal_o <= cal_next;
          end
        end
        OP_BUSY: begin
          if (op_done_i) begin
            op_state_reg <= OP_IDLE;
          end
        end
        default: op_state_reg <= OP_IDLE;
      endcase
    end
  end

  cal_interval_sched u_sched (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .restart_i(ctrl_wr),
    .enable_i(meas_req),
    .sel_i(cal_sel_reg),
    .op_done_i(op_fin),
    .op_was_cal_i(op_is_cal_o),
    .cal_next_o(cal_next)
  );

  cell_uv_tracker #(.CELLS(CELLS)) u_uv (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .clear_i(ctrl_wr),
    .check_i(uv_check),
    .below_i(cell_below_uv_i),
    .mask_i(swen_reg),
    .reached_o(uv_reached)
  );

  // Switch drive; halts open the switches on the next edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      switch_on_o <= '0;
    end else begin
      for (int n = 0; n < CELLS; n++) begin
        switch_on_o[n] <= running && !ctrl_wr && timing_reg &&
          !expire && !cal_fault && !temp_fault && swen_reg[n] &&
          !uv_reached[n] &&
          !(auto_md && !mode[cb_stop_pkg::GROUP_BIT] &&
            elapsed_reg >= cell_exp_reg[n]) &&
          !(manual_md && ctrl_reg[cb_stop_pkg::PAUSE_BIT] &&
            op_state_reg == OP_BUSY);
      end
    end
  end

  // Filter copy waits for the running operation; set beats clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      copy_pend_reg <= 1'b0;
      iir_copy_o <= 1'b0;
    end else begin
      iir_copy_o <= copy_pend_reg && op_state_reg == OP_IDLE;
      if (do_wr && avs_address_i == cb_stop_pkg::OFS_DATA &&
          avs_byteenable_i[0] && avs_writedata_i[cb_stop_pkg::COPY_BIT]) begin
        copy_pend_reg <= 1'b1;
      end else if (op_state_reg == OP_IDLE) begin
        copy_pend_reg <= 1'b0;
      end
    end
  end

  // Post-expiry hold: larger of fixed time and a sixteenth of expiry
  assign ext_len = (16'(limit >> 4) > 16'(HOLD_EXT_TICKS)) ?
    16'(limit >> 4) : 16'(HOLD_EXT_TICKS);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_cnt_reg <= '0;
    end else if (ctrl_wr) begin
      ext_cnt_reg <= '0;
    end else if (expire) begin
      ext_cnt_reg <= ext_len;
    end else if (tick && ext_cnt_reg != '0) begin
      ext_cnt_reg <= ext_cnt_reg - 16'h1;
    end
  end

  // Hold only in discharge and automated modes, faults included
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shutdown_hold_o <= 1'b0;
    end else begin
      case (hold_sel)
        cb_stop_pkg::HOLD_TIMER: shutdown_hold_o <= am_md && timing_reg;
        cb_stop_pkg::HOLD_EXT: shutdown_hold_o <= am_md &&
          (timing_reg || ext_cnt_reg != '0 ||
           (state_reg != cb_stop_pkg::ST_IDLE &&
            limit == cb_stop_pkg::EXP_INFINITE));
        cb_stop_pkg::HOLD_WRITE: shutdown_hold_o <= am_md;
        default: shutdown_hold_o <= 1'b0;
      endcase
    end
  end
endmodule

// ==== test/cb_stop_monitor.sv ====
// Port checker for the balancing stop controller.
// Assumes a bind onto the controller top; one clock domain.
`timescale 1ns/1ns
module cb_stop_monitor (
  input wire logic ref_clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [7:0] avs_address_i, // Address
  input wire logic avs_read_i, // Read
  input wire logic avs_write_i, // Write
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic op_start_o, // Op start
  input wire logic op_is_cal_o, // Op kind
  input wire logic op_done_i, // Op end
  input wire logic iir_copy_o // Copy pulse
);
  logic busy_reg;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Op in flight, rebuilt from the ports alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) busy_reg <= 1'b0;
    else if (op_start_o) busy_reg <= 1'b1;
    else if (op_done_i) busy_reg <= 1'b0;
  end
  sequence s_rd(logic [7:0] a);
    avs_read_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence
  sequence s_copy;
    avs_write_i && !avs_waitrequest_o && avs_writedata_i[0] &&
      avs_address_i == cb_stop_pkg::OFS_DATA;
  endsequence
  AST_WAIT_FIRST: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o) else $error("no stall on new request");
  AST_WAIT_ONE: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("stall longer than one cycle");
  AST_COPY_RD0: assert property (s_rd(cb_stop_pkg::OFS_DATA) |->
    avs_readdata_o == 32'h0) else $error("copy strobe reads nonzero");
  AST_UNMAP_RD0: assert property (s_rd(8'h20) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read nonzero");
  AST_START_IDLE: assert property (op_start_o |-> !busy_reg)
    else $error("op started while busy");
  AST_COPY_IDLE: assert property (iir_copy_o |-> !busy_reg)
    else $error("copy during operation");
  AST_COPY_SOON: assert property (s_copy |-> ##[1:40] iir_copy_o)
    else $error("copy never issued");
  AST_CAL_HELD: assert property (busy_reg && !op_done_i && !avs_write_i
    |=> $stable(op_is_cal_o)) else $error("op kind changed mid op");
endmodule

// ==== test/adc_engine_model.sv ====
// ADC engine model: answers each op start with one done pulse.
// Assumes the bench sets the latency before each start.
`timescale 1ns/1ns
module adc_engine_model (
  input wire logic ref_clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic start_i, // Op start
  input wire logic [3:0] lat_i, // Extra cycles before done
  output logic done_o // Op finished pulse
);
  logic [4:0] cnt_reg;
  // Countdown per op; slow and prompt answers both occur
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 5'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= cnt_reg == 5'h1;
      if (start_i) cnt_reg <= {1'b0, lat_i} + 5'h1;
      else if (cnt_reg != 5'h0) cnt_reg <= cnt_reg - 5'h1;
    end
  end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the balancing stop controller.
// Assumes the ADC model as partner and a 4-cycle timer tick.
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, e, g)
module tb;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic avs_waitrequest_o, op_start_o, op_is_cal_o, op_done_i;
  logic cal_range_alert_i = 1'b0, thermal_fault_i = 1'b0;
  logic iir_copy_o, shutdown_hold_o;
  logic [13:0] switch_on_o, swen, below = 14'h0;
  logic [3:0] lat = 4'h2;
  logic [31:0] rd_q[$];
  logic cal_q[$];
  int n_fail = 0, samples_checked = 0, n_ops = 0, n_cp = 0;
  int per_tab[8] = '{0, 2, 4, 8, 12, 16, 24, 32};
  always #10 ref_clk_i = ~ref_clk_i;
  cell_balance_cal_stop_ctrl #(.TICK_CYCLES(4), .HOLD_EXT_TICKS(3)) uut (
    .ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
    .avs_waitrequest_o, .op_start_o, .op_is_cal_o, .op_done_i,
    .cal_range_alert_i, .cell_below_uv_i(below), .thermal_fault_i,
    .switch_on_o, .iir_copy_o, .shutdown_hold_o);
  adc_engine_model adc (.ref_clk_i, .resetn_i, .start_i(op_start_o),
    .lat_i(lat), .done_o(op_done_i));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task complete_run;
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Each visible result takes the oldest note
  always @(negedge ref_clk_i) begin
    if (avs_read_i && !avs_waitrequest_o)
      `CHK("rdata", rd_q.size() ? rd_q.pop_front() : 32'hx,
        avs_readdata_o);
    if (iir_copy_o) n_cp++;
    if (op_start_o) begin
      n_ops++;
      lat = 4'($urandom_range(7));
      `CHK("op_is_cal", cal_q.size() ? cal_q.pop_front() : 1'bx,
        op_is_cal_o);
    end
  end
  // Held request; a bounded wait ends a hung bus
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    @(posedge ref_clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_ops(input int t);
    int n;
    for (n = 0; n_ops < t && n < 3000; n++) @(posedge ref_clk_i);
    if (n >= 3000) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Abort, load interval and expiry, then restart with ctrl
  task automatic start(input logic [2:0] sel, input logic [31:0] ex, ctrl);
    bus(1'b1, cb_stop_pkg::OFS_CTRL, 32'h0);
    repeat (20) @(posedge ref_clk_i);
    cal_q.delete();
    n_ops = 0;
    n_cp = 0;
    bus(1'b1, cb_stop_pkg::OFS_CAL, {29'h0, sel});
    bus(1'b1, cb_stop_pkg::OFS_GRP_EXP, ex);
    for (int k = 0; k < 80; k++)
      cal_q.push_back(sel != 0 && k % per_tab[sel] == 0);
    bus(1'b1, cb_stop_pkg::OFS_CTRL, ctrl);
  endtask
  initial begin
    int s;
    s = $urandom(32'h23db);
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(cb_stop_pkg::OFS_STATUS, 32'h0);
    rd(cb_stop_pkg::OFS_CAL, 32'h0);
    rd(8'h20, 32'h0);
    swen = 14'($urandom_range(16383)) | 14'h1;
    bus(1'b1, cb_stop_pkg::OFS_SWEN, {18'h0, swen});
    // Schedule for every interval code, auto group with measurements
    for (int sel = 0; sel < 8; sel++) begin
      start(3'(sel), 32'h3ff, 32'h226);
      wait_ops(per_tab[sel] + 2);
    end
    // Interval ignored without measurements: no ops at all
    start(3'h7, 32'h3ff, 32'h206);
    repeat (60) @(posedge ref_clk_i);
    `CHK("ops", 0, n_ops);
    rd(cb_stop_pkg::OFS_STATUS, 32'h1);
    // Copy mid run, then range fault; timer runs on to expiry
    start(3'h1, 32'h1e, 32'h2226);
    wait_ops(2);
    bus(1'b1, cb_stop_pkg::OFS_DATA, 32'h1);
    rd(cb_stop_pkg::OFS_DATA, 32'h0);
    repeat (10) @(posedge ref_clk_i);
    `CHK("copies", 1, n_cp);
    cal_range_alert_i <= 1'b1;
    repeat (30) @(posedge ref_clk_i);
    `CHK("hold", 1, shutdown_hold_o);
    cal_q.delete();
    cal_range_alert_i <= 1'b0;
    repeat (150) @(posedge ref_clk_i);
    `CHK("sw_off", 0, switch_on_o);
    `CHK("hold", 0, shutdown_hold_o);
    rd(cb_stop_pkg::OFS_STATUS, 32'hf);
    rd(cb_stop_pkg::OFS_TIMER, 32'h1e);
    // Manual ignores thermal exit; discharge halts on it
    thermal_fault_i <= 1'b1;
    start(3'h0, 32'h3, 32'h102);
    repeat (40) @(posedge ref_clk_i);
    rd(cb_stop_pkg::OFS_STATUS, 32'h6);
    rd(cb_stop_pkg::OFS_TIMER, 32'h3);
    start(3'h0, 32'h5, 32'h101);
    repeat (40) @(posedge ref_clk_i);
    rd(cb_stop_pkg::OFS_STATUS, 32'h17);
    rd(cb_stop_pkg::OFS_TIMER, 32'h5);
    `CHK("sw_off", 0, switch_on_o);
    thermal_fault_i <= 1'b0;
    // Every enabled cell under the limit: normal stop, no done
    below <= 14'h3fff;
    start(3'h0, 32'h3ff, 32'h236);
    repeat (40) @(posedge ref_clk_i);
    rd(cb_stop_pkg::OFS_STATUS, 32'h2);
    rd(cb_stop_pkg::OFS_UV, {18'h0, swen});
    `CHK("sw_off", 0, switch_on_o);
    below <= 14'h0;
    bus(1'b1, cb_stop_pkg::OFS_CTRL, 32'h0);
    rd(cb_stop_pkg::OFS_STATUS, 32'h0);
    rd(cb_stop_pkg::OFS_UV, 32'h0);
    complete_run();
  end
endmodule
bind cell_balance_cal_stop_ctrl cb_stop_monitor mon (.ref_clk_i,
  .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .op_start_o, .op_is_cal_o,
  .op_done_i, .iir_copy_o);
